// *** dv/ibc_bus_model.sv ***
// Purpose: far side of the two-wire bus: pull-ups, one slave, one master
// Assumes: behavioural, master bit period 800 ns
// Notes: released lines float high through the pull-ups
`timescale 1ns/100ps

module ibc_bus_model #(
  parameter logic [6:0] SLV_ADR = 7'h3c
) (
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic m_scl_low = 1'b0;
  logic m_sda_low = 1'b0;
  logic ack_low = 1'b0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  int cnt = 0;

  // wired-and with pull-ups
  assign o_scl = !(i_scl_oe || m_scl_low);
  assign o_sda = !(i_sda_oe || m_sda_low || ack_low);

  // ==========================================================================
  // slave: framing and ack
  always @(negedge o_sda) if (o_scl) begin
    cnt = 0;
    first = 1'b1;
  end
  always @(posedge o_sda) if (o_scl) begin
    cnt = 0;
    first = 1'b0;
  end
  always @(posedge o_scl) begin
    if (cnt < 8) sh = {sh[6:0], o_sda};
    cnt++;
  end
  // ack is low in the ninth clock, only for our own address
  always @(negedge o_scl) begin
    ack_low = (cnt == 8 && first && sh[7:1] == SLV_ADR);
    if (cnt == 9) begin
      cnt = 0;
      first = 1'b0;
    end
  end

  // ==========================================================================
  // master: start, byte with ack, stop; waits while the clock is stretched
  // pin changes land 25 ns after a system clock edge, never on it
  task automatic settle(input int t);
    #t;
    #((175 - $time % 100) % 100);
  endtask : settle

  task automatic mstart();
    settle(0);
    m_sda_low = 1'b1;
    settle(400);
    m_scl_low = 1'b1;
  endtask : mstart

  task automatic mbyte(input logic [7:0] b, output logic ack);
    settle(0);
    for (int j = 0; j < 9; j++) begin
      m_sda_low = (j < 8) ? !b[7-j] : 1'b0;
      settle(400);
      m_scl_low = 1'b0;
      wait (o_scl);
      settle(400);
      ack = o_sda;
      m_scl_low = 1'b1;
    end
  endtask : mbyte

  // bus free time after the stop, so a following start is a real edge
  task automatic mstop();
    settle(0);
    m_sda_low = 1'b1;
    settle(400);
    m_scl_low = 1'b0;
    wait (o_scl);
    settle(400);
    m_sda_low = 1'b0;
    settle(400);
  endtask : mstop
endmodule : ibc_bus_model

// *** dv/ibc_properties.sv ***
// Purpose: port-level properties of the two-wire controller
// Assumes: one clock domain, synchronous active-high reset
// Notes: register contents are judged by the bench, not here
`timescale 1ns/100ps

module ibc_properties (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register bus
  input wire ibc_pkg::ibc_apb_req_s i_apb,
  input wire ibc_pkg::ibc_apb_rsp_s o_apb,
  // two-wire pins
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe
);
  import ibc_pkg::*;
  logic mapped;
  logic acc;

  // ==========================================================================
  // helpers: word index decode and access phase
  assign mapped = i_apb.paddr[11:2] inside {IBC_IDX_AUX, IBC_IDX_CTL, IBC_IDX_STAT,
                                            IBC_IDX_DATA, IBC_IDX_ADR};
  assign acc = i_apb.psel && i_apb.penable;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // register bus answers
  chk_one_wait_state: assert property ($rose(acc) |=> o_apb.pready)
    else $error("pready not one cycle after first access cycle");
  chk_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (o_apb.pready |-> $past(acc))
    else $error("pready without an access phase");
  chk_rdata_form: assert property (o_apb.prdata[31:8] == 24'h0 &&
                                   (o_apb.pready || o_apb.prdata == 32'h0))
    else $error("read data outside its valid cycle or upper bits set");
  chk_err_unmapped: assert property (o_apb.pready |-> (o_apb.pslverr == !mapped))
    else $error("slave error does not match address decode");

  // ==========================================================================
  // pins
  chk_open_drain: assert property (o_scl == 1'b0 && o_sda == 1'b0)
    else $error("pin drives a high level");
  // reset must win even though default disable is the reset itself
  chk_reset_quiet: assert property (disable iff (1'b0)
                                    i_rst |=> !o_scl_oe && !o_sda_oe && !o_apb.pready)
    else $error("outputs active after reset edge");
  chk_start_clock: assert property ($rose(o_sda_oe) && !o_scl_oe && i_scl
                                    |-> ##[1:500] o_scl_oe)
    else $error("start condition not followed by clock low");

  // main scenarios
  cov_err: cover property (o_apb.pready && o_apb.pslverr);
  cov_start: cover property ($rose(o_sda_oe) && i_scl);
  cov_clock: cover property ($rose(o_scl_oe));
endmodule : ibc_properties

bind ibc_top ibc_properties ibc_properties_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_apb(i_apb), .o_apb(o_apb), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));

// *** dv/test_ibc_top.sv ***
// Purpose: self-checking bench for the two-wire controller
// Assumes: bus model at the far side, 100 ns system clock
// Notes: tests are sequences of register calls with expected values
`timescale 1ns/100ps

module test_ibc_top;
  import ibc_pkg::*;
  logic clk;
  logic rst;
  ibc_apb_req_s apb;
  ibc_apb_rsp_s rsp;
  logic scl, sda, scl_oe, sda_oe, lerr, a;
  logic [7:0] d;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] abyte [4] = '{8'h78, 8'h22, 8'h79, 8'h23};
  logic [7:0] code [4] = '{8'h18, 8'h20, 8'h40, 8'h48};

  ibc_top ibc_top_i (.i_clk_sys(clk), .i_rst(rst), .i_apb(apb), .o_apb(rsp),
    .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe));
  ibc_bus_model ibc_bus_model_i (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_scl(scl),
    .o_sda(sda));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one APB transfer; an idle cycle ahead keeps drives one per time step
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00},
             pwdata: {24'h0, wd}};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata[7:0];
    lerr = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : bus

  // poll the flag, then compare the status code
  task automatic waitflag(input logic [7:0] exp);
    logic [7:0] r;
    int n;
    r = 8'h00;
    n = 0;
    while (r[IBC_CTL_SI] !== 1'b1 && n < 3000) begin
      bus(1'b0, IBC_IDX_CTL, 8'h00, r);
      n++;
    end
    chk({7'h0, r[IBC_CTL_SI]}, 8'h01);
    bus(1'b0, IBC_IDX_STAT, 8'h00, r);
    chk(r, exp);
  endtask : waitflag

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results();
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    apb = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, IBC_IDX_CTL, 8'h00, d); chk(d, 8'h00);
    bus(1'b0, IBC_IDX_STAT, 8'h00, d); chk(d, 8'hf8);
    bus(1'b0, IBC_IDX_ADR, 8'h00, d); chk(d, 8'h00);
    bus(1'b0, 10'h001, 8'h00, d); chk({7'h0, lerr}, 8'h01);
    bus(1'b1, IBC_IDX_STAT, 8'h00, d);
    bus(1'b0, IBC_IDX_STAT, 8'h00, d); chk(d, 8'hf8);
    bus(1'b1, IBC_IDX_AUX, 8'h08, d);
    bus(1'b1, IBC_IDX_AUX, 8'h00, d);
    bus(1'b0, IBC_IDX_AUX, 8'h00, d); chk(d, 8'h08);
    // start request with the block disabled does nothing
    bus(1'b1, IBC_IDX_CTL, 8'h20, d);
    repeat (200) @(posedge clk);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    bus(1'b0, IBC_IDX_STAT, 8'h00, d); chk(d, 8'hf8);
    bus(1'b1, IBC_IDX_CTL, 8'h4a, d);
    bus(1'b0, IBC_IDX_CTL, 8'h00, d); chk(d, 8'h42);
    // master address phase: ack and no-ack, write and read
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IBC_IDX_CTL, 8'he2, d);
      waitflag(IBC_ST_START);
      repeat (200) @(posedge clk);
      chk({7'h0, scl_oe}, 8'h01);
      waitflag(IBC_ST_START);
      bus(1'b1, IBC_IDX_DATA, abyte[i], d);
      bus(1'b1, IBC_IDX_CTL, 8'hc2, d);
      waitflag(code[i]);
      bus(1'b1, IBC_IDX_CTL, 8'hd2, d);
      repeat (100) @(posedge clk);
      bus(1'b0, IBC_IDX_CTL, 8'h00, d); chk(d, 8'hc2);
    end
    // data byte unanswered, then repeated start switches to receiving
    bus(1'b1, IBC_IDX_CTL, 8'he2, d);
    waitflag(IBC_ST_START);
    bus(1'b1, IBC_IDX_DATA, 8'h78, d);
    bus(1'b1, IBC_IDX_CTL, 8'hc2, d);
    waitflag(IBC_ST_MT_ADDR);
    bus(1'b1, IBC_IDX_DATA, 8'h5a, d);
    bus(1'b1, IBC_IDX_CTL, 8'hc2, d);
    waitflag(8'h30);
    bus(1'b1, IBC_IDX_CTL, 8'he2, d);
    waitflag(IBC_ST_RSTART);
    bus(1'b1, IBC_IDX_DATA, 8'h79, d);
    bus(1'b1, IBC_IDX_CTL, 8'hc2, d);
    waitflag(IBC_ST_MR_ADDR);
    bus(1'b1, IBC_IDX_CTL, 8'hd2, d);
    repeat (100) @(posedge clk);
    bus(1'b0, IBC_IDX_CTL, 8'h00, d); chk(d, 8'hc2);
    // slave receiver: own address, data, then no-ack after ack enable drops
    bus(1'b1, IBC_IDX_ADR, 8'ha5, d);
    bus(1'b1, IBC_IDX_CTL, 8'h44, d);
    ibc_bus_model_i.mstart();
    ibc_bus_model_i.mbyte(8'ha4, a); chk({7'h0, a}, 8'h00);
    waitflag(IBC_ST_SR_OWN);
    bus(1'b1, IBC_IDX_CTL, 8'h44, d);
    ibc_bus_model_i.mbyte(8'h5a, a); chk({7'h0, a}, 8'h00);
    waitflag(IBC_ST_SR_DATA);
    bus(1'b0, IBC_IDX_DATA, 8'h00, d); chk(d, 8'h5a);
    bus(1'b1, IBC_IDX_CTL, 8'h40, d);
    ibc_bus_model_i.mbyte(8'h33, a); chk({7'h0, a}, 8'h01);
    waitflag(8'h88);
    bus(1'b1, IBC_IDX_CTL, 8'h40, d);
    ibc_bus_model_i.mstop();
    // ack enable clear: own address ignored
    ibc_bus_model_i.mstart();
    ibc_bus_model_i.mbyte(8'ha4, a); chk({7'h0, a}, 8'h01);
    ibc_bus_model_i.mstop();
    bus(1'b0, IBC_IDX_STAT, 8'h00, d); chk(d, 8'hf8);
    // recognition resumes; general call answered
    bus(1'b1, IBC_IDX_CTL, 8'h44, d);
    ibc_bus_model_i.mstart();
    ibc_bus_model_i.mbyte(8'h00, a); chk({7'h0, a}, 8'h00);
    waitflag(IBC_ST_SR_GC);
    bus(1'b1, IBC_IDX_CTL, 8'h44, d);
    ibc_bus_model_i.mstop();
    waitflag(IBC_ST_SR_STOP);
    bus(1'b1, IBC_IDX_CTL, 8'h44, d);
    // second reset in mid-run reopens the write-once register
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, IBC_IDX_AUX, 8'h00, d); chk(d, 8'h00);
    bus(1'b0, IBC_IDX_STAT, 8'h00, d); chk(d, 8'hf8);
    results();
  end
endmodule : test_ibc_top

// *** hw/ibc_pkg.sv ***
// Purpose: constants, types and state layout of the byte-level two-wire bus controller
// Assumes: 10 MHz system clock, APB register access, open-drain bus pins
// Notes: register indexes are word indexes, byte address is four times the index
package ibc_pkg;

  // ==========================================================================
  // register map (word indexes)
  localparam logic [9:0] IBC_IDX_AUX = 10'h08e;
  localparam logic [9:0] IBC_IDX_CTL = 10'h0d8;
  localparam logic [9:0] IBC_IDX_STAT = 10'h0d9;
  localparam logic [9:0] IBC_IDX_DATA = 10'h0da;
  localparam logic [9:0] IBC_IDX_ADR = 10'h0db;

  // ==========================================================================
  // control, aux and address register fields
  localparam int IBC_CTL_CR2 = 7;
  localparam int IBC_CTL_EN = 6;
  localparam int IBC_CTL_STA = 5;
  localparam int IBC_CTL_STO = 4;
  localparam int IBC_CTL_SI = 3;
  localparam int IBC_CTL_AA = 2;
  localparam int IBC_CTL_CR1 = 1;
  localparam int IBC_CTL_CR0 = 0;
  localparam int IBC_AUX_FAST = 3;
  localparam int IBC_ADR_GC = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] IBC_CTL_RST = 8'h00;
  localparam logic [7:0] IBC_ADR_RST = 8'h00;
  localparam logic [7:0] IBC_AUX_RST = 8'h00;

  // ==========================================================================
  // status codes
  localparam logic [7:0] IBC_ST_IDLE = 8'hf8;
  localparam logic [7:0] IBC_ST_START = 8'h08;
  localparam logic [7:0] IBC_ST_RSTART = 8'h10;
  localparam logic [7:0] IBC_ST_MT_ADDR = 8'h18;
  localparam logic [7:0] IBC_ST_MT_DATA = 8'h28;
  localparam logic [7:0] IBC_ST_LOST = 8'h38;
  localparam logic [7:0] IBC_ST_MR_ADDR = 8'h40;
  localparam logic [7:0] IBC_ST_MR_DATA = 8'h50;
  localparam logic [7:0] IBC_ST_SR_OWN = 8'h60;
  localparam logic [7:0] IBC_ST_LOST_OWN = 8'h68;
  localparam logic [7:0] IBC_ST_SR_GC = 8'h70;
  localparam logic [7:0] IBC_ST_LOST_GC = 8'h78;
  localparam logic [7:0] IBC_ST_SR_DATA = 8'h80;
  localparam logic [7:0] IBC_ST_GC_DATA = 8'h90;
  localparam logic [7:0] IBC_ST_SR_STOP = 8'ha0;
  localparam logic [7:0] IBC_ST_LOST_RD = 8'hb0;
  localparam logic [7:0] IBC_ST_NACK_OFS = 8'h08;

  // ==========================================================================
  // bit period divisors of the system clock, indexed by {cr2, cr1, cr0}
  localparam logic [7:0][9:0] IBC_DIV_TBL = {10'h0f0, 10'h03c, 10'h078, 10'h3c0,
                                             10'h0a0, 10'h0c0, 10'h0e0, 10'h100};

  // ==========================================================================
  // types
  typedef enum logic [4:0] {
    M_IDLE = 5'b00001,
    M_START = 5'b00010,
    M_RUN = 5'b00100,
    M_RSTA = 5'b01000,
    M_STOP = 5'b10000
  } ibc_mst_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ibc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ibc_apb_rsp_s;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] stat;
    logic [7:0] data;
    logic [7:0] adr;
    logic [7:0] aux;
    logic aux_lock;
    ibc_mst_e mstate;
    logic ph;
    logic [9:0] cnt;
    logic [3:0] bc;
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic scl_oe, sda_oe;
    logic mst, tx, rd, xmit, addrp, addressed, gc, lost, hold, ackr;
    logic bus_free, busy, rsta;
    ibc_apb_rsp_s apb;
  } ibc_state_s;

endpackage : ibc_pkg

// *** hw/ibc_top.sv ***
// Purpose: byte-level two-wire bus controller, master tx/rx and slave rx
// Assumes: pins are open-drain, level on the wire comes back on i_scl/i_sda
// Notes: one wait state on every APB access; slave transmit is not carried
//
// Our own choice: the APB register port.
`timescale 1ns/100ps

module ibc_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register bus
  input wire ibc_pkg::ibc_apb_req_s i_apb,
  output ibc_pkg::ibc_apb_rsp_s o_apb,
  // two-wire bus pins
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);
  import ibc_pkg::*;

  // ==========================================================================
  // state
  ibc_state_s q;
  ibc_state_s n;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic en;
  logic clr_si;
  logic acc;
  logic commit;
  logic [9:0] widx;
  logic [9:0] half;
  logic match_own;
  logic match_gc;
  logic [7:0] code;

  // ==========================================================================
  // next-state logic
  always_comb begin
    n = q;
    // two-flop synchronisers, edge detection only on the second stage onward
    n.scl_m = i_scl;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = i_sda;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    scl_rise = q.scl_s & ~q.scl_p;
    scl_fall = ~q.scl_s & q.scl_p;
    start_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop_det = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    en = q.ctl[IBC_CTL_EN];
    clr_si = 1'b0;
    match_own = 1'b0;
    match_gc = 1'b0;
    code = IBC_ST_IDLE;
    // rate bits only shape the clock this end makes as master
    half = IBC_DIV_TBL[{q.ctl[IBC_CTL_CR2], q.ctl[IBC_CTL_CR1], q.ctl[IBC_CTL_CR0]}] >> 1;
    if (q.aux[IBC_AUX_FAST]) begin
      half = half >> 1;
    end

    // apb slave: answer registered one cycle into the access phase
    widx = i_apb.paddr[11:2];
    acc = i_apb.psel & i_apb.penable & ~q.apb.pready;
    commit = i_apb.psel & i_apb.penable & q.apb.pready & i_apb.pwrite;
    n.apb = '0;
    if (acc) begin
      n.apb.pready = 1'b1;
      unique case (widx)
        IBC_IDX_CTL: n.apb.prdata = {24'h000000, q.ctl};
        IBC_IDX_STAT: n.apb.prdata = {24'h000000, q.stat};
        IBC_IDX_DATA: n.apb.prdata = {24'h000000, q.data};
        IBC_IDX_ADR: n.apb.prdata = {24'h000000, q.adr};
        IBC_IDX_AUX: n.apb.prdata = {24'h000000, q.aux};
        default: n.apb.pslverr = 1'b1;
      endcase
    end
    if (commit) begin
      unique case (widx)
        IBC_IDX_CTL: begin
          // the flag can only be cleared by software, writing one is ignored
          n.ctl = {i_apb.pwdata[7:4], q.ctl[IBC_CTL_SI] & i_apb.pwdata[3], i_apb.pwdata[2:0]};
          clr_si = q.ctl[IBC_CTL_SI] & ~i_apb.pwdata[3];
        end
        IBC_IDX_DATA: n.data = i_apb.pwdata[7:0];
        IBC_IDX_ADR: n.adr = i_apb.pwdata[7:0];
        IBC_IDX_AUX: begin
          // write once: later writes are dropped
          if (!q.aux_lock) begin
            n.aux = i_apb.pwdata[7:0];
            n.aux_lock = 1'b1;
          end
        end
        default: n.ctl = q.ctl;
      endcase
    end

    // resume after software clears the flag; that same write carries stop or start
    if (clr_si) begin
      n.stat = IBC_ST_IDLE;
      n.hold = 1'b0;
      if (q.mst) begin
        if (q.stat == IBC_ST_START || q.stat == IBC_ST_RSTART) begin
          // address byte: its direction bit picks transmit or receive
          n.tx = ~q.data[0];
          n.rd = q.data[0];
          n.xmit = 1'b1;
          n.sda_oe = ~q.data[7];
        end else if (n.ctl[IBC_CTL_STO]) begin
          n.mstate = M_STOP;
          n.ph = 1'b0;
          n.cnt = '0;
        end else if (n.ctl[IBC_CTL_STA]) begin
          n.mstate = M_RSTA;
          n.ph = 1'b0;
          n.cnt = '0;
        end else begin
          n.xmit = q.tx;
          n.sda_oe = q.tx & ~q.data[7];
        end
      end
    end

    // master clock and condition generator
    unique case (q.mstate)
      M_IDLE: begin
        n.scl_oe = n.hold;
        // start waits for a free bus and no pending flag
        if (q.ctl[IBC_CTL_STA] && !q.ctl[IBC_CTL_SI] && q.bus_free && !q.busy) begin
          n.mstate = M_START;
          n.cnt = '0;
          n.sda_oe = 1'b1;
          n.rsta = 1'b0;
        end
      end
      M_START: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt >= half) begin
          n.scl_oe = 1'b1;
          n.mst = 1'b1;
          n.addrp = 1'b1;
          n.stat = q.rsta ? IBC_ST_RSTART : IBC_ST_START;
          n.ctl[IBC_CTL_SI] = 1'b1;
          n.mstate = M_RUN;
          n.ph = 1'b0;
          n.cnt = '0;
        end
      end
      M_RUN: begin
        if (q.ctl[IBC_CTL_SI]) begin
          // clock held low while the flag waits for software
          n.scl_oe = 1'b1;
          n.ph = 1'b0;
          n.cnt = '0;
        end else if (!q.ph) begin
          n.scl_oe = 1'b1;
          n.cnt = q.cnt + 10'h001;
          if (q.cnt >= half) begin
            n.scl_oe = 1'b0;
            n.ph = 1'b1;
            n.cnt = '0;
          end
        end else if (q.scl_s) begin
          // high time counts only once the wire is high: stretching slaves win
          n.cnt = q.cnt + 10'h001;
          if (q.cnt >= half) begin
            n.scl_oe = 1'b1;
            n.ph = 1'b0;
            n.cnt = '0;
          end
        end
      end
      M_RSTA, M_STOP: begin
        n.sda_oe = (q.mstate == M_STOP);
        if (!q.ph) begin
          n.scl_oe = 1'b1;
          n.cnt = q.cnt + 10'h001;
          if (q.cnt >= half) begin
            n.scl_oe = 1'b0;
            n.ph = 1'b1;
            n.cnt = '0;
          end
        end else if (q.scl_s) begin
          n.cnt = q.cnt + 10'h001;
          if (q.cnt >= half) begin
            n.cnt = '0;
            n.sda_oe = (q.mstate == M_RSTA);
            if (q.mstate == M_RSTA) begin
              n.rsta = 1'b1;
              n.mstate = M_START;
            end else begin
              n.ctl[IBC_CTL_STO] = 1'b0;
              n.mst = 1'b0;
              n.mstate = M_IDLE;
            end
          end
        end
      end
      default: n.mstate = M_IDLE;
    endcase

    // bus monitor and bit engine, running even with acknowledge disabled
    if (start_det) begin
      n.bus_free = 1'b0;
      n.busy = 1'b1;
      n.bc = '0;
      n.addrp = 1'b1;
      n.xmit = 1'b0;
      if (q.addressed && !q.mst) begin
        n.stat = IBC_ST_SR_STOP;
        n.ctl[IBC_CTL_SI] = 1'b1;
        n.addressed = 1'b0;
      end
    end else if (stop_det) begin
      n.bus_free = 1'b1;
      n.busy = 1'b0;
      n.bc = '0;
      n.addrp = 1'b0;
      if (q.addressed) begin
        n.stat = IBC_ST_SR_STOP;
        n.ctl[IBC_CTL_SI] = 1'b1;
        n.addressed = 1'b0;
      end
    end else if (q.busy && scl_rise) begin
      if (q.bc < 4'h8) begin
        // sent a one but the wire is low: another master owns the bus
        if (q.xmit && q.mst && q.data[7] && !q.sda_s) begin
          n.lost = 1'b1;
          n.mst = 1'b0;
          n.xmit = 1'b0;
          n.mstate = M_IDLE;
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
        end
        n.data = {q.data[6:0], q.sda_s};
        n.bc = q.bc + 4'h1;
      end else begin
        n.ackr = ~q.sda_s;
        n.bc = 4'h9;
      end
    end else if (q.busy && scl_fall) begin
      if (q.bc < 4'h8) begin
        n.sda_oe = q.xmit & ~q.data[7];
      end else if (q.bc == 4'h8) begin
        n.sda_oe = 1'b0;
        if (!q.xmit) begin
          match_own = q.data[7:1] == q.adr[7:1];
          match_gc = (q.data == 8'h00) & q.adr[IBC_ADR_GC];
          if (q.mst) begin
            n.sda_oe = q.ctl[IBC_CTL_AA];
          end else if (q.addrp) begin
            // own address only with write, except after a lost arbitration
            if (q.ctl[IBC_CTL_AA] && ((match_own && (!q.data[0] || q.lost)) || match_gc)) begin
              n.addressed = 1'b1;
              n.gc = match_gc & ~match_own;
              n.rd = q.data[0];
              n.sda_oe = 1'b1;
            end
          end else if (q.addressed) begin
            n.sda_oe = q.ctl[IBC_CTL_AA];
          end
        end
      end else begin
        n.sda_oe = 1'b0;
        n.bc = '0;
        n.addrp = 1'b0;
        n.xmit = 1'b0;
        if (q.mst) begin
          if (q.addrp) begin
            code = q.tx ? IBC_ST_MT_ADDR : IBC_ST_MR_ADDR;
          end else begin
            code = q.tx ? IBC_ST_MT_DATA : IBC_ST_MR_DATA;
          end
          n.stat = q.ackr ? code : code + IBC_ST_NACK_OFS;
          n.ctl[IBC_CTL_SI] = 1'b1;
        end else if (q.lost) begin
          // addressed after losing: report as slave, else plain loss
          if (q.addressed) begin
            n.stat = q.gc ? IBC_ST_LOST_GC : (q.rd ? IBC_ST_LOST_RD : IBC_ST_LOST_OWN);
          end else begin
            n.stat = IBC_ST_LOST;
          end
          n.hold = q.addressed;
          n.scl_oe = q.addressed;
          n.addressed = q.addressed & ~q.rd;
          n.lost = 1'b0;
          n.ctl[IBC_CTL_SI] = 1'b1;
        end else if (q.addressed) begin
          if (q.addrp) begin
            n.stat = q.gc ? IBC_ST_SR_GC : IBC_ST_SR_OWN;
          end else begin
            code = q.gc ? IBC_ST_GC_DATA : IBC_ST_SR_DATA;
            n.stat = q.ackr ? code : code + IBC_ST_NACK_OFS;
            n.addressed = q.ackr;
          end
          n.hold = 1'b1;
          n.scl_oe = 1'b1;
          n.ctl[IBC_CTL_SI] = 1'b1;
        end
      end
    end

    // disabled: take no part in the bus, only keep the pins released
    if (!en) begin
      n.mstate = M_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.mst = 1'b0;
      n.busy = 1'b0;
      n.bus_free = 1'b1;
      n.addressed = 1'b0;
      n.lost = 1'b0;
      n.hold = 1'b0;
      n.xmit = 1'b0;
      n.bc = '0;
    end
    // enable and rate bits are only ever written by software
    n.ctl[IBC_CTL_EN] = commit && widx == IBC_IDX_CTL ? i_apb.pwdata[IBC_CTL_EN] : q.ctl[IBC_CTL_EN];
  end

  // ==========================================================================
  // state register; synchroniser stages reset high like an idle bus
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= '0;
      q.ctl <= IBC_CTL_RST;
      q.adr <= IBC_ADR_RST;
      q.aux <= IBC_AUX_RST;
      q.stat <= IBC_ST_IDLE;
      q.mstate <= M_IDLE;
      q.bus_free <= 1'b1;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // outputs: open-drain pins only ever pull low
  assign o_apb = q.apb;
  assign o_scl_oe = q.scl_oe;
  assign o_sda_oe = q.sda_oe;
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;

endmodule : ibc_top
